// >>> hdl/iscfe_capture.sv
`timescale 1ns/1ps
`default_nettype none
module iscfe_capture
    import iscfe_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic reset, // Async reset, high
    input wire logic sensor_pixel_clock, // Link clock from sensor
    input wire logic [PIX_W-1:0] sensor_pixel_bus, // Pixel data
    input wire logic sensor_horizontal_sync, // Line sync
    input wire logic sensor_vertical_sync, // Frame sync
    input wire iscfe_cfg_t cfg, // Quasi-static settings
    input wire logic dma_frame_done, // Frame stored pulse
    output logic frame_start_event, // Frame start pulse
    output logic dma_done_event, // Frame stored pulse
    output logic sav_event, // Start code pulse
    output logic eav_event, // End code pulse
    output logic out_valid, // Word strobe
    output iscfe_word_t out_word // Formatted word
);
    localparam int DEPTH = 1 << FIFO_AW;
    logic [4:0] rst_pix_ff; // Pixel-side reset stretch
    logic rst_pix; // Core reset on the pixel side
    logic rst_cfg; // Settings-sync reset, released first
    iscfe_cfg_t cfg_s1_ff, cfg_s2_ff, cfg_p_ff; // Settings crossing
    logic [PIX_W-1:0] px_ff; // Sampled bus
    logic hs_ff, vs_ff, hs_d_ff, vs_d_ff; // Polarity-fixed syncs
    logic hs_rise, vs_rise, emb, gray;
    logic [7:0] raw8, rev8, rx_byte;
    logic [1:0] pre_ff; // Preamble bytes matched
    logic emb_act_ff, had_sav_ff, blank_seen_ff;
    logic sav, eav, fs, cap_emb, cap_ext, cap, line_go, line_start;
    logic [2:0] skip_ff, nxt_skip;
    logic cap_frame_ff; // Current frame is kept
    iscfe_sync_t st_ff;
    logic [7:0] lcnt_ff, dcnt_ff;
    logic [1:0] bcnt_ff, last_idx, bidx;
    logic [23:0] sh_ff; // Earlier bytes of a unit
    logic [PIX_W-1:0] ghold_ff; // First gray pixel
    logic unit_end;
    logic [31:0] u, wdata;
    logic alt;
    logic [4:0] r5, b5;
    logic [5:0] g6;
    logic [7:0] dec8, hacc_ff, hbase, hsum, vacc_ff, vbase, vsum;
    logic keep_h, keep_v_ff;
    iscfe_word_t word;
    logic wr, full, empty;
    iscfe_word_t mem_ff [DEPTH]; // Crossing buffer
    logic [FIFO_AW:0] wbin_ff, wgray_ff, nxt_wbin, rg1_ff, rg2_ff, rg3_ff;
    logic [FIFO_AW:0] rbin_ff, rgray_ff, nxt_rbin, wg1_ff, wg2_ff, wg3_ff;
    logic [2:0] evt_tog_ff, es1_ff, es2_ff, es3_ff, evt_ff;
    logic dma_ff, out_valid_ff;
    iscfe_word_t out_word_ff;

    // Reset released on the pixel clock; the core waits until the settings
    // sync holds real values, so a sync polarity never fakes an edge
    always_ff @(posedge sensor_pixel_clock or posedge reset) begin
        if (reset) begin
            rst_pix_ff <= 5'h1f;
        end else begin
            rst_pix_ff <= {rst_pix_ff[3:0], 1'b0};
        end
    end
    assign rst_cfg = rst_pix_ff[1];
    assign rst_pix = rst_pix_ff[4];

    // Settings are static while capturing, so per-bit sync is enough
    always_ff @(posedge sensor_pixel_clock or posedge rst_cfg) begin
        if (rst_cfg) begin
            cfg_s1_ff <= '0;
            cfg_s2_ff <= '0;
            cfg_p_ff <= '0;
        end else begin
            cfg_s1_ff <= cfg;
            cfg_s2_ff <= cfg_s1_ff;
            cfg_p_ff <= cfg_s2_ff;
        end
    end

    // Sensor pins sampled on the pixel clock itself
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            px_ff <= '0;
            {hs_ff, vs_ff, hs_d_ff, vs_d_ff} <= 4'h0;
        end else begin
            px_ff <= sensor_pixel_bus;
            hs_ff <= sensor_horizontal_sync ^ cfg_p_ff.hsync_active_low;
            vs_ff <= sensor_vertical_sync ^ cfg_p_ff.vsync_active_low;
            hs_d_ff <= hs_ff;
            vs_d_ff <= vs_ff;
        end
    end
    assign hs_rise = hs_ff & ~hs_d_ff;
    assign vs_rise = vs_ff & ~vs_d_ff;
    assign emb = cfg_p_ff.embedded_sync;
    assign gray = (cfg_p_ff.input_format == FMT_GRAY);
    assign raw8 = px_ff[7:0];

    // Bit reversal per byte
    for (genvar i = 0; i < 8; i++) begin : g_rev
        assign rev8[i] = raw8[7-i];
    end
    assign rx_byte = (cfg_p_ff.bit_swap && !gray) ? rev8 : raw8;

    // Reference code detector
    assign sav = emb && pre_ff == PRE_LEN && raw8 == SAV_XY;
    assign eav = emb && pre_ff == PRE_LEN && raw8 == EAV_XY;
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            pre_ff <= 2'h0;
            {emb_act_ff, had_sav_ff, blank_seen_ff} <= 3'h0;
        end else begin
            if (raw8 == CODE_FF) begin
                pre_ff <= 2'h1;
            end else if (pre_ff != 2'h0 && pre_ff != PRE_LEN && raw8 == CODE_00) begin
                pre_ff <= pre_ff + 2'h1;
            end else begin
                pre_ff <= 2'h0;
            end
            if (sav) begin
                emb_act_ff <= 1'b1;
                had_sav_ff <= 1'b1;
                blank_seen_ff <= 1'b0;
            end else if (eav) begin
                emb_act_ff <= 1'b0;
                had_sav_ff <= 1'b0;
                // Two end codes in a row mark a blanking line
                if (!had_sav_ff) begin
                    blank_seen_ff <= 1'b1;
                end
            end
        end
    end
    // Codes and preamble bytes never reach the word builder
    assign cap_emb = emb_act_ff && pre_ff == 2'h0 && raw8 != CODE_FF && raw8 != CODE_00;
    assign fs = emb ? (sav & blank_seen_ff) : vs_rise;

    // Frame skip counter
    assign nxt_skip = (skip_ff >= cfg_p_ff.frame_skip) ? 3'h0 : skip_ff + 3'h1;
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            skip_ff <= SKIP_RST;
            cap_frame_ff <= 1'b0;
        end else if (fs) begin
            skip_ff <= nxt_skip;
            cap_frame_ff <= (nxt_skip == 3'h0);
        end
    end

    // External sync tracking
    assign line_go = hs_rise && (st_ff == ST_LINE ||
        (st_ff == ST_BLANK && lcnt_ff >= cfg_p_ff.frame_start_blank_lines));
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            st_ff <= ST_VWAIT;
            lcnt_ff <= 8'h00;
            dcnt_ff <= 8'h00;
        end else if (vs_rise) begin
            st_ff <= ST_BLANK;
            lcnt_ff <= 8'h00;
        end else if (line_go) begin
            dcnt_ff <= 8'h01;
            st_ff <= (cfg_p_ff.line_start_delay_clocks <= 8'h01) ? ST_ACTIVE : ST_DELAY;
        end else begin
            case (st_ff)
                ST_BLANK: begin
                    if (hs_rise) begin
                        lcnt_ff <= lcnt_ff + 8'h01;
                    end
                end
                ST_DELAY: begin
                    if (!hs_ff) begin
                        st_ff <= ST_LINE;
                    end else begin
                        dcnt_ff <= dcnt_ff + 8'h01;
                        if (dcnt_ff + 8'h01 >= cfg_p_ff.line_start_delay_clocks) begin
                            st_ff <= ST_ACTIVE;
                        end
                    end
                end
                ST_ACTIVE: begin
                    if (!hs_ff) begin
                        st_ff <= ST_LINE;
                    end
                end
                default: begin
                end
            endcase
        end
    end
    assign cap_ext = hs_ff && (st_ff == ST_ACTIVE ||
        (line_go && cfg_p_ff.line_start_delay_clocks == 8'h00));
    assign cap = cap_frame_ff && (emb ? cap_emb : cap_ext);
    assign line_start = emb ? sav : line_go;

    // Bytes or pixels per formed unit
    always_comb begin
        case (cfg_p_ff.input_format)
            FMT_YCC: last_idx = 2'h3;
            FMT_RGB888: last_idx = 2'h2;
            FMT_RGB565: last_idx = 2'h1;
            default: last_idx = cfg_p_ff.grayscale_packing_select ? 2'h0 : 2'h1;
        endcase
    end
    // A line opening restarts the unit even when its first byte is kept
    assign bidx = line_start ? 2'h0 : bcnt_ff;
    assign unit_end = cap && bidx == last_idx;
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            bcnt_ff <= 2'h0;
            sh_ff <= '0;
            ghold_ff <= '0;
        end else if (cap) begin
            bcnt_ff <= unit_end ? 2'h0 : bidx + 2'h1;
            sh_ff <= {sh_ff[15:0], rx_byte};
            ghold_ff <= px_ff;
        end else if (line_start) begin
            bcnt_ff <= 2'h0;
        end
    end

    // Reorder and repack into a word
    assign u = {sh_ff, rx_byte};
    assign alt = (cfg_p_ff.rgb_byte_order_select == RGB_ORD_ALT);
    assign r5 = alt ? u[12:8] : u[15:11];
    assign g6 = alt ? {u[2:0], u[15:13]} : {u[10:8], u[7:5]};
    assign b5 = alt ? u[7:3] : u[4:0];
    always_comb begin
        wdata = '0;
        case (cfg_p_ff.input_format)
            FMT_YCC: begin
                // Canonical word is Cb, Y0, Cr, Y1
                case (cfg_p_ff.ycc_order)
                    2'h0: wdata = u;
                    2'h1: wdata = {u[15:8], u[23:16], u[31:24], u[7:0]};
                    2'h2: wdata = {u[23:16], u[31:24], u[7:0], u[15:8]};
                    default: wdata = {u[7:0], u[31:24], u[23:16], u[15:8]};
                endcase
            end
            FMT_RGB888: wdata = {8'h00, u[23:0]};
            // Green loses its low bit to fit a 15-bit display
            FMT_RGB565: wdata = {16'h0000, 1'b0, r5, g6[5:1], b5};
            FMT_GRAY: begin
                if (cfg_p_ff.grayscale_packing_select) begin
                    wdata = {px_ff, GS_PAD, 16'h0000};
                end else begin
                    wdata = {ghold_ff, GS_PAD, px_ff, GS_PAD};
                end
            end
            default: wdata = '0;
        endcase
    end

    // Preview decimation, same ratio both ways; low values clamp to 16
    assign dec8 = {1'b0, (cfg_p_ff.dec_value < DEC_MIN) ? DEC_MIN : cfg_p_ff.dec_value};
    assign hbase = line_start ? 8'h00 : hacc_ff;
    assign hsum = hbase + DEC_STEP;
    assign keep_h = hsum >= dec8;
    assign vbase = fs ? 8'h00 : vacc_ff;
    assign vsum = vbase + DEC_STEP;
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            hacc_ff <= 8'h00;
            vacc_ff <= 8'h00;
            keep_v_ff <= 1'b0;
        end else begin
            if (unit_end) begin
                hacc_ff <= keep_h ? hsum - dec8 : hsum;
            end else if (line_start) begin
                hacc_ff <= 8'h00;
            end
            if (line_start) begin
                keep_v_ff <= vsum >= dec8;
                vacc_ff <= (vsum >= dec8) ? vsum - dec8 : vsum;
            end else if (fs) begin
                vacc_ff <= 8'h00;
            end
        end
    end
    assign word.data = wdata;
    assign word.to_preview = gray | (keep_h & keep_v_ff);
    assign word.to_codec = cfg_p_ff.codec_enable & ~gray;
    // A full buffer drops the word; the reader drains one word per mclk
    assign wr = unit_end & (word.to_preview | word.to_codec) & ~full;

    // Write side of the gray-pointer buffer
    assign nxt_wbin = wbin_ff + 1'b1;
    assign full = wgray_ff == {~rg3_ff[FIFO_AW:FIFO_AW-1], rg3_ff[FIFO_AW-2:0]};
    always_ff @(posedge sensor_pixel_clock) begin
        if (wr) begin
            mem_ff[wbin_ff[FIFO_AW-1:0]] <= word;
        end
    end
    always_ff @(posedge sensor_pixel_clock or posedge rst_pix) begin
        if (rst_pix) begin
            wbin_ff <= '0;
            wgray_ff <= '0;
            {rg1_ff, rg2_ff, rg3_ff} <= '0;
            evt_tog_ff <= 3'h0;
        end else begin
            if (wr) begin
                wbin_ff <= nxt_wbin;
                wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
            end
            rg1_ff <= rgray_ff;
            rg2_ff <= rg1_ff;
            rg3_ff <= rg2_ff;
            evt_tog_ff <= evt_tog_ff ^ {eav, sav, fs};
        end
    end

    // Read side and event pulses on the system clock
    assign empty = rgray_ff == wg3_ff;
    assign nxt_rbin = rbin_ff + 1'b1;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rbin_ff <= '0;
            rgray_ff <= '0;
            {wg1_ff, wg2_ff, wg3_ff} <= '0;
            {es1_ff, es2_ff, es3_ff, evt_ff} <= '0;
            dma_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_word_ff <= '0;
        end else begin
            wg1_ff <= wgray_ff;
            wg2_ff <= wg1_ff;
            wg3_ff <= wg2_ff;
            es1_ff <= evt_tog_ff;
            es2_ff <= es1_ff;
            es3_ff <= es2_ff;
            evt_ff <= es2_ff ^ es3_ff;
            dma_ff <= dma_frame_done;
            out_valid_ff <= !empty;
            if (!empty) begin
                out_word_ff <= mem_ff[rbin_ff[FIFO_AW-1:0]];
                rbin_ff <= nxt_rbin;
                rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
            end
        end
    end
    assign frame_start_event = evt_ff[0];
    assign sav_event = evt_ff[1];
    assign eav_event = evt_ff[2];
    assign dma_done_event = dma_ff;
    assign out_valid = out_valid_ff;
    assign out_word = out_word_ff;

    a_skip_every: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        fs && cfg_p_ff.frame_skip == 3'h0 |=> cap_frame_ff) else $error("frame not kept");
    a_skip_wrap: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        $rose(cap_frame_ff) |-> $past(fs) && skip_ff == 3'h0) else $error("skip wrap");
    a_gray_single: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        wr && gray && cfg_p_ff.grayscale_packing_select |-> word.data[19:0] == 20'h0)
        else $error("gray pack");
    a_gray_nocodec: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        wr && gray |-> !word.to_codec) else $error("codec in gray");
    a_sav_opens: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        emb && pre_ff == 2'h3 && raw8 == 8'h80 |=> emb_act_ff) else $error("sav missed");
    a_blank_drop: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        cap && emb |-> emb_act_ff && raw8 != 8'hff) else $error("blank captured");
    a_delay_hold: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        st_ff == ST_DELAY |-> !cap) else $error("capture in delay");
    a_rgb_555: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        wr && cfg_p_ff.input_format == FMT_RGB565 |-> word.data[31:15] == 17'h0)
        else $error("not 555");
    a_dec_unity: assert property (@(posedge sensor_pixel_clock) disable iff (rst_pix)
        unit_end && dec8 == 8'h10 |-> keep_h) else $error("unity dropped");
endmodule
`default_nettype wire

// >>> hdl/iscfe_pkg.sv
package iscfe_pkg;
    localparam int PIX_W = 12;
    localparam int FIFO_AW = 2;
    localparam logic [7:0] CODE_FF = 8'hff;
    localparam logic [7:0] CODE_00 = 8'h00;
    localparam logic [7:0] SAV_XY = 8'h80;
    localparam logic [7:0] EAV_XY = 8'h9d;
    localparam logic [1:0] PRE_LEN = 2'h3;
    localparam logic [7:0] DEC_STEP = 8'h10;
    localparam logic [6:0] DEC_MIN = 7'h10;
    localparam logic [2:0] SKIP_RST = 3'h7;
    localparam logic [3:0] GS_PAD = 4'h0;
    localparam logic [1:0] RGB_ORD_ALT = 2'h2;
    // Input formats, one-hot
    typedef enum logic [3:0] {
        FMT_YCC = 4'h1, FMT_RGB888 = 4'h2, FMT_RGB565 = 4'h4, FMT_GRAY = 4'h8
    } iscfe_fmt_t;
    // External sync tracker
    typedef enum logic [4:0] {
        ST_VWAIT = 5'h01, ST_BLANK = 5'h02, ST_LINE = 5'h04,
        ST_DELAY = 5'h08, ST_ACTIVE = 5'h10
    } iscfe_sync_t;
    typedef struct packed {
        logic embedded_sync;
        logic hsync_active_low;
        logic vsync_active_low;
        iscfe_fmt_t input_format;
        logic [1:0] ycc_order;
        logic [1:0] rgb_byte_order_select;
        logic bit_swap;
        logic grayscale_packing_select;
        logic codec_enable;
        logic [2:0] frame_skip;
        logic [7:0] frame_start_blank_lines;
        logic [7:0] line_start_delay_clocks;
        logic [6:0] dec_value;
    } iscfe_cfg_t;
    typedef struct packed {
        logic [31:0] data;
        logic to_preview;
        logic to_codec;
    } iscfe_word_t;
endpackage

// >>> verif/iscfe_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural sensor: owns pixel clock, pixel bus and both syncs
module iscfe_sensor_model (
    output logic pclk, // Pixel clock, stopped between frames
    output logic [11:0] bus, // Pixel data
    output logic hs, // Line sync pin
    output logic vs, // Frame sync pin
    input wire logic hs_low, // Line sync active low
    input wire logic vs_low // Frame sync active low
);
    logic hs_on = 1'b0; // Logical line sync
    logic vs_on = 1'b0; // Logical frame sync
    initial begin
        pclk = 1'b0;
        bus = 12'h000;
    end
    // Pin level follows the programmed polarity
    assign hs = hs_on ^ hs_low;
    assign vs = vs_on ^ vs_low;
    // One 6 ns period; data moves while the clock is low
    task automatic tick(input logic [11:0] d, input logic h, input logic v);
        bus = d;
        hs_on = h;
        vs_on = v;
        #3 pclk = 1'b1;
        #3 pclk = 1'b0;
    endtask
    // Blanking clocks carry noise, never a stale value
    task automatic idle(input int n);
        repeat (n) tick(12'($urandom), 1'b0, 1'b0);
    endtask
    // Frame sync pulse with settle time around it
    task automatic vpulse();
        idle(8);
        repeat (2) tick(12'($urandom), 1'b0, 1'b1);
        idle(4);
    endtask
    // Junk clocks under sync, payload, then line gap
    task automatic line(input logic [11:0] px[$], input int pre, input logic h);
        repeat (pre) tick(12'($urandom), h, 1'b0);
        foreach (px[i]) tick(px[i], h, 1'b0);
        idle(20);
        bus = ~bus; // Released bus shows no stale value
    endtask
endmodule
`default_nettype wire

// >>> verif/iscfe_capture_bench.sv
`timescale 1ns/1ps
`default_nettype none
module iscfe_capture_bench;
    import iscfe_pkg::*;
    logic mclk = 1'b0; // System clock, slower than pixel clock
    logic reset = 1'b1; // Async reset
    logic pclk; // Pixel clock from model
    logic [PIX_W-1:0] pbus; // Pixel bus from model
    logic hs, vs; // Sync pins from model
    logic dma_frame_done = 1'b0; // Frame stored strobe
    iscfe_cfg_t cfg = '0; // Settings
    logic frame_start_event, dma_done_event, sav_event, eav_event, out_valid; // Strobes
    iscfe_word_t out_word; // Output word
    iscfe_word_t got_q[$], exp_q[$]; // Seen and expected words
    int err_count = 0; // Mismatches
    int n_checks = 0; // Comparisons
    int n_fs = 0, n_sav = 0, n_eav = 0, n_dma = 0; // Event tallies

    iscfe_capture uut (.mclk(mclk), .reset(reset), .sensor_pixel_clock(pclk),
        .sensor_pixel_bus(pbus), .sensor_horizontal_sync(hs), .sensor_vertical_sync(vs),
        .cfg(cfg), .dma_frame_done(dma_frame_done), .frame_start_event(frame_start_event),
        .dma_done_event(dma_done_event), .sav_event(sav_event), .eav_event(eav_event),
        .out_valid(out_valid), .out_word(out_word));
    iscfe_sensor_model sens (.pclk(pclk), .bus(pbus), .hs(hs), .vs(vs),
        .hs_low(cfg.hsync_active_low), .vs_low(cfg.vsync_active_low));

    initial begin
        forever #10 mclk = ~mclk;
    end
    // Collect words and tally one-cycle strobes, mid-cycle where they settle
    always @(negedge mclk) begin
        if (out_valid === 1'b1) got_q.push_back(out_word);
        if (frame_start_event === 1'b1) n_fs++;
        if (sav_event === 1'b1) n_sav++;
        if (eav_event === 1'b1) n_eav++;
        if (dma_done_event === 1'b1) n_dma++;
    end

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Let words drain, then compare in order
    task automatic cmp_words(input string m);
        repeat (60) @(posedge mclk);
        chk(got_q.size() == exp_q.size(), m);
        foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i] === exp_q[i], m);
        got_q = {};
        exp_q = {};
        $display("test %s done", m);
    endtask
    // Polarity only changes under reset, so no false sync edge is seen
    task automatic do_reset();
        @(negedge mclk);
        reset = 1'b1;
        cfg.hsync_active_low = 1'($urandom);
        cfg.vsync_active_low = 1'($urandom);
        sens.idle(4);
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        sens.idle(8);
    endtask

    // Expected 32-bit word for one unit of input
    function automatic logic [31:0] unit_word(input iscfe_cfg_t c, input logic [11:0] p[4]);
        logic [7:0] b[4];
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 8; j++) b[i][j] = c.bit_swap ? p[i][7-j] : p[i][j];
        end
        case (c.input_format)
            FMT_YCC: case (c.ycc_order)
                2'h0: unit_word = {b[0], b[1], b[2], b[3]};
                2'h1: unit_word = {b[2], b[1], b[0], b[3]};
                2'h2: unit_word = {b[1], b[0], b[3], b[2]};
                default: unit_word = {b[3], b[0], b[1], b[2]};
            endcase
            FMT_RGB888: unit_word = {8'h00, b[0], b[1], b[2]};
            FMT_RGB565: if (c.rgb_byte_order_select == RGB_ORD_ALT) begin
                unit_word = {17'h0, b[0][4:0], b[1][2:0], b[0][7:6], b[1][7:3]};
            end else begin
                unit_word = {17'h0, b[0][7:3], b[0][2:0], b[1][7:6], b[1][4:0]};
            end
            default: unit_word = c.grayscale_packing_select ? {p[0], 20'h0} :
                {p[0], 4'h0, p[1], 4'h0};
        endcase
    endfunction

    // One sync-framed frame; keep says whether the skip counter selects it
    task automatic run_ext(input int nl, input logic keep);
        logic [11:0] px[$];
        logic [11:0] p[4];
        int n, nu, d, av, ah, fs0;
        logic kv, kh;
        iscfe_word_t w;
        n = cfg.input_format == FMT_YCC ? 4 : cfg.input_format == FMT_RGB888 ? 3 : 2;
        if (cfg.input_format == FMT_GRAY && cfg.grayscale_packing_select) n = 1;
        nu = cfg.input_format == FMT_YCC ? 4 : 3;
        d = cfg.dec_value < DEC_MIN ? 16 : int'(cfg.dec_value);
        av = 0;
        fs0 = n_fs;
        sens.vpulse();
        repeat (cfg.frame_start_blank_lines) sens.line(px, 4, 1'b1);
        for (int l = 0; l < nl; l++) begin
            px = {};
            av += 16;
            kv = av >= d;
            if (kv) av -= d;
            ah = 0;
            for (int u = 0; u < nu; u++) begin
                ah += 16;
                kh = ah >= d;
                if (kh) ah -= d;
                for (int k = 0; k < 4; k++) p[k] = 12'($urandom);
                for (int k = 0; k < n; k++) px.push_back(p[k]);
                w.data = unit_word(cfg, p);
                w.to_preview = cfg.input_format == FMT_GRAY || (kh && kv);
                w.to_codec = cfg.codec_enable && cfg.input_format != FMT_GRAY;
                if (keep && (w.to_preview || w.to_codec)) exp_q.push_back(w);
            end
            sens.line(px, cfg.line_start_delay_clocks, 1'b1);
        end
        repeat (4) @(posedge mclk);
        chk(n_fs == fs0 + 1, "frame start count");
    endtask

    // Two end-code-only lines, then two active lines between codes
    task automatic run_emb();
        logic [11:0] px[$];
        logic [11:0] p[4];
        iscfe_word_t w;
        sens.idle(8);
        for (int l = 0; l < 4; l++) begin
            px = {};
            if (l >= 2) begin
                px = {12'h0ff, 12'h000, 12'h000, 12'h080};
                for (int u = 0; u < 2; u++) begin
                    for (int k = 0; k < 4; k++) p[k] = {4'($urandom), 8'($urandom_range(254, 1))};
                    px = {px, p[0], p[1], p[2], p[3]};
                    w.data = unit_word(cfg, p);
                    w.to_preview = 1'b1;
                    w.to_codec = cfg.codec_enable;
                    exp_q.push_back(w);
                end
            end
            px = {px, 12'h0ff, 12'h000, 12'h000, 12'h09d};
            sens.line(px, 0, 1'($urandom));
        end
    endtask

    initial begin
        int fs0;
        void'($urandom(32'h3d89a264));
        cfg.input_format = FMT_YCC;
        cfg.dec_value = 7'h10;
        do_reset();
        for (int o = 0; o < 4; o++) begin
            @(negedge mclk);
            cfg.ycc_order = 2'(o);
            cfg.codec_enable = 1'($urandom);
            cfg.frame_start_blank_lines = 8'($urandom_range(2, 0));
            cfg.line_start_delay_clocks = 8'($urandom_range(3, 0));
            run_ext(2, 1'b1);
            cmp_words("ycc order");
        end
        for (int m = 0; m < 8; m++) begin
            @(negedge mclk);
            cfg.input_format = m < 2 ? FMT_RGB888 : m < 6 ? FMT_RGB565 : FMT_GRAY;
            cfg.bit_swap = m[0];
            cfg.rgb_byte_order_select = m < 4 ? 2'h0 : RGB_ORD_ALT;
            cfg.grayscale_packing_select = m[0];
            cfg.codec_enable = 1'b1;
            run_ext(1, 1'b1);
            cmp_words("rgb and gray layout");
        end
        for (int m = 0; m < 4; m++) begin
            @(negedge mclk);
            cfg.input_format = FMT_YCC;
            cfg.bit_swap = 1'b0;
            cfg.dec_value = m == 0 ? 7'h05 : m == 1 ? 7'h18 : 7'h20;
            cfg.codec_enable = m[0];
            run_ext(3, 1'b1);
            cmp_words("decimation");
        end
        @(negedge mclk);
        cfg.dec_value = 7'h10;
        cfg.frame_skip = 3'h2;
        do_reset();
        fs0 = n_fs;
        for (int f = 0; f < 4; f++) run_ext(1, f % 3 == 0);
        cmp_words("frame skip");
        chk(n_fs == fs0 + 4, "skipped frames still flagged");
        @(negedge mclk);
        cfg.frame_skip = 3'h0;
        cfg.embedded_sync = 1'b1;
        cfg.ycc_order = 2'($urandom);
        do_reset();
        fs0 = n_fs;
        run_emb();
        cmp_words("embedded codes");
        chk(n_sav == 2 && n_eav == 4, "code strobes");
        chk(n_fs == fs0 + 1, "embedded frame start");
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            dma_frame_done = 1'b1;
            @(negedge mclk);
            dma_frame_done = 1'b0;
        end
        repeat (4) @(posedge mclk);
        chk(n_dma == 3, "frame stored strobes");
        $display("test events done");
        end_sim();
    end
    // Watchdog well past the expected run length
    initial begin
        #200us;
        err_count++;
        $display("BAD %0t watchdog", $time);
        end_sim();
    end
endmodule
`default_nettype wire
